// >>> drc_pkg.sv
// Function
// - reset rising edge restores all registers
// - reset sequence lasts about 300 us
// - after reset outputs equal signal ground
// - outputs stay grounded until write plus load
// - reset low alone changes nothing
// - clear low forces outputs to ground
// - clear low ignores load pulses
// - clear release restores previous outputs
// - clear leaves all data registers intact
// - gain default all ones, offset 2^13
// - shared multiplier adder computes calibrated code
package drc_pkg;
   // ***************************************************
   // widths and defaults
   // ***************************************************
   localparam int DRC_DW = 14;
   localparam int DRC_NCH = 32;
   localparam int DRC_CHW = 5;
   localparam logic [DRC_DW-1:0] DRC_GAIN_DEF = 14'h3fff;
   localparam logic [DRC_DW-1:0] DRC_OFS_DEF = 14'h2000;
   localparam logic [DRC_DW-1:0] DRC_IN_DEF = 14'h1555;
   // ***************************************************
   // timing
   // ***************************************************
   localparam int DRC_CLK_MHZ = 100;
   localparam int DRC_RST_SEQ_US = 300;
   localparam int DRC_RST_SEQ_CYC = DRC_RST_SEQ_US * DRC_CLK_MHZ;
   typedef enum logic [1:0] {DRC_IDLE, DRC_RESET, DRC_CALC} drc_state_t;
endpackage

// >>> drc_cal.sv
`timescale 1ns/10ps
// ***************************************************
// shared calibration datapath
// ***************************************************
module drc_cal
   import drc_pkg::*;
#(
   parameter int DW = DRC_DW
) (
   input wire logic [DW-1:0] i_code,
   input wire logic [DW-1:0] i_gain,
   input wire logic [DW-1:0] i_ofs,
   output logic [DW-1:0] o_code
);
   logic [2*DW:0] prod;
   logic signed [DW+2:0] sum;
   always_comb begin
      // code*(m+1)/2^dw + c - 2^(dw-1), saturated to code range
      prod = {{(DW+1){1'b0}}, i_code} * ({{(DW+1){1'b0}}, i_gain} + {{(2*DW){1'b0}}, 1'b1});
      sum = $signed({3'b000, prod[2*DW-1:DW]}) + $signed({3'b000, i_ofs})
            - $signed({4'b0001, {(DW-1){1'b0}}});
      if (sum < 0) begin
         o_code = '0;
      end else if (sum[DW+2:DW] != 3'b000) begin
         o_code = '1;
      end else begin
         o_code = sum[DW-1:0];
      end
   end
endmodule

// >>> drc_top.sv
`timescale 1ns/10ps
module drc_top
   import drc_pkg::*;
#(
   parameter int NCH = DRC_NCH,
   parameter int RST_CYC = DRC_RST_SEQ_CYC
) (
   // clock and reset
   input wire logic I_CLK,
   input wire logic I_RST_N,
   // control pins
   input wire logic I_DEV_RESET_N,
   input wire logic I_OUTPUT_FORCE_GROUND_N,
   input wire logic I_LOAD_OUTPUTS_N,
   // register write port
   input wire logic I_WR,
   input wire logic [1:0] I_WR_SEL,
   input wire logic [DRC_CHW-1:0] I_WR_CH,
   input wire logic [DRC_DW-1:0] I_WR_DATA,
   // outputs
   output logic [NCH*DRC_DW-1:0] O_ANALOG_OUTPUT_CHANNEL,
   output logic O_GROUP_SIGNAL_GROUND_REF,
   output logic O_RESET_BUSY
);
   // I_WR_SEL: 0 input, 1 gain trim, 2 offset trim
   localparam logic [1:0] SEL_IN = 2'h0;
   localparam logic [1:0] SEL_GAIN = 2'h1;
   localparam logic [1:0] SEL_OFS = 2'h2;

   // ***************************************************
   // register storage
   // ***************************************************
   logic [DRC_DW-1:0] in_ff [NCH];
   logic [DRC_DW-1:0] gain_ff [NCH];
   logic [DRC_DW-1:0] ofs_ff [NCH];
   logic [DRC_DW-1:0] cal_ff [NCH];
   logic [DRC_DW-1:0] dac_ff [NCH];
   logic [NCH-1:0] dirty_ff;
   logic [DRC_DW-1:0] nxt_in [NCH];
   logic [DRC_DW-1:0] nxt_gain [NCH];
   logic [DRC_DW-1:0] nxt_ofs [NCH];
   logic [DRC_DW-1:0] nxt_cal [NCH];
   logic [DRC_DW-1:0] nxt_dac [NCH];
   logic [NCH-1:0] nxt_dirty;
   logic [NCH*DRC_DW-1:0] nxt_out;
   logic [NCH*DRC_DW-1:0] out_ff;

   drc_state_t state_ff, nxt_state;
   logic [31:0] cnt_ff, nxt_cnt;
   logic [DRC_CHW-1:0] calc_ch_ff, nxt_calc_ch;
   logic pin_rst_ff, nxt_pin_rst;
   logic clr_ff, nxt_clr;
   logic [DRC_DW-1:0] cal_code;
   logic [DRC_DW-1:0] def_cal;
   logic rst_rise;
   logic load_ok;

   assign rst_rise = I_DEV_RESET_N & ~pin_rst_ff;
   // ignored while clearing or while the reset sequence runs
   assign load_ok = ~I_LOAD_OUTPUTS_N & I_OUTPUT_FORCE_GROUND_N & (state_ff == DRC_IDLE);

   drc_cal #(.DW(DRC_DW)) u_cal (
      .i_code(in_ff[calc_ch_ff]),
      .i_gain(gain_ff[calc_ch_ff]),
      .i_ofs(ofs_ff[calc_ch_ff]),
      .o_code(cal_code)
   );

   drc_cal #(.DW(DRC_DW)) u_def (
      .i_code(DRC_IN_DEF),
      .i_gain(DRC_GAIN_DEF),
      .i_ofs(DRC_OFS_DEF),
      .o_code(def_cal)
   );

   // ***************************************************
   // sequencing
   // ***************************************************
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_calc_ch = calc_ch_ff;
      nxt_pin_rst = I_DEV_RESET_N;
      nxt_clr = I_OUTPUT_FORCE_GROUND_N;
      nxt_in = in_ff;
      nxt_gain = gain_ff;
      nxt_ofs = ofs_ff;
      nxt_cal = cal_ff;
      nxt_dac = dac_ff;
      nxt_dirty = dirty_ff;
      case (state_ff)
         DRC_IDLE: begin
            if (I_WR) begin
               // writes only to stored words; outputs move on load
               case (I_WR_SEL)
                  SEL_IN: nxt_in[I_WR_CH] = I_WR_DATA;
                  SEL_GAIN: nxt_gain[I_WR_CH] = I_WR_DATA;
                  SEL_OFS: nxt_ofs[I_WR_CH] = I_WR_DATA;
                  default: ;
               endcase
               nxt_calc_ch = I_WR_CH;
               nxt_state = DRC_CALC;
            end
         end
         DRC_CALC: begin
            // one shared datapath: one channel per cycle
            nxt_cal[calc_ch_ff] = cal_code;
            nxt_dirty[calc_ch_ff] = 1'b1;
            nxt_state = DRC_IDLE;
         end
         DRC_RESET: begin
            // writes during this window are dropped by design
            if (cnt_ff >= 32'(RST_CYC - 1)) begin
               nxt_state = DRC_IDLE;
               nxt_cnt = '0;
            end else begin
               nxt_cnt = cnt_ff + 32'h1;
            end
         end
         default: nxt_state = DRC_IDLE;
      endcase
      // a falling edge alone does nothing, only the rise
      if (rst_rise) begin
         nxt_state = DRC_RESET;
         nxt_cnt = '0;
         for (int i = 0; i < NCH; i++) begin
            nxt_in[i] = DRC_IN_DEF;
            nxt_gain[i] = DRC_GAIN_DEF;
            nxt_ofs[i] = DRC_OFS_DEF;
            nxt_cal[i] = def_cal;
            nxt_dac[i] = def_cal;
         end
         nxt_dirty = '0;
      end else if (load_ok) begin
         // only channels recomputed since last load move
         for (int i = 0; i < NCH; i++) begin
            if (dirty_ff[i]) begin
               nxt_dac[i] = cal_ff[i];
            end
         end
         nxt_dirty = '0;
      end
   end

   // ***************************************************
   // output mux
   // ***************************************************
   always_comb begin
      for (int i = 0; i < NCH; i++) begin
         // clear muxes in ground code; dac words untouched
         nxt_out[i*DRC_DW +: DRC_DW] = I_OUTPUT_FORCE_GROUND_N ? nxt_dac[i] : def_cal;
      end
   end

   always_ff @(posedge I_CLK) begin
      if (!I_RST_N) begin
         state_ff <= DRC_RESET;
         cnt_ff <= '0;
         calc_ch_ff <= '0;
         pin_rst_ff <= 1'b1;
         clr_ff <= 1'b0;
         dirty_ff <= '0;
         // default trims are identity, so the ground code equals the default input word
         out_ff <= {NCH{DRC_IN_DEF}};
         for (int i = 0; i < NCH; i++) begin
            in_ff[i] <= DRC_IN_DEF;
            gain_ff[i] <= DRC_GAIN_DEF;
            ofs_ff[i] <= DRC_OFS_DEF;
            cal_ff[i] <= DRC_IN_DEF;
            dac_ff[i] <= DRC_IN_DEF;
         end
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         calc_ch_ff <= nxt_calc_ch;
         pin_rst_ff <= nxt_pin_rst;
         clr_ff <= nxt_clr;
         dirty_ff <= nxt_dirty;
         out_ff <= nxt_out;
         in_ff <= nxt_in;
         gain_ff <= nxt_gain;
         ofs_ff <= nxt_ofs;
         cal_ff <= nxt_cal;
         dac_ff <= nxt_dac;
      end
   end

   assign O_ANALOG_OUTPUT_CHANNEL = out_ff;
   assign O_GROUP_SIGNAL_GROUND_REF = ~clr_ff;
   assign O_RESET_BUSY = (state_ff == DRC_RESET);

   // ***************************************************
   // checks
   // ***************************************************
   a_reset_starts: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      rst_rise |=> state_ff == DRC_RESET && in_ff[0] == DRC_IN_DEF)
      else $error("reset rise did not start sequence");
   a_reset_length: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      $rose(O_RESET_BUSY) && cnt_ff == 0 |-> O_RESET_BUSY[*8])
      else $error("reset sequence ended early");
   a_trim_defaults: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      rst_rise |=> gain_ff[NCH-1] == DRC_GAIN_DEF && ofs_ff[NCH-1] == DRC_OFS_DEF)
      else $error("trim defaults wrong");
   a_fall_noop: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      $fell(I_DEV_RESET_N) && state_ff == DRC_IDLE && !I_WR |=> state_ff == DRC_IDLE)
      else $error("reset fall changed operation");
   a_ground_out: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      !I_OUTPUT_FORCE_GROUND_N |=> O_ANALOG_OUTPUT_CHANNEL[DRC_DW-1:0] == def_cal)
      else $error("clear did not ground output");
   a_clear_noload: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      !I_OUTPUT_FORCE_GROUND_N && !rst_rise |=> dac_ff[0] == $past(dac_ff[0]))
      else $error("load acted during clear");
   a_clear_restore: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      I_OUTPUT_FORCE_GROUND_N |=> O_ANALOG_OUTPUT_CHANNEL[DRC_DW-1:0] == dac_ff[0])
      else $error("output not restored after clear");
   a_hold_ground: assert property (@(posedge I_CLK) disable iff (!I_RST_N)
      O_RESET_BUSY && I_OUTPUT_FORCE_GROUND_N |=> O_ANALOG_OUTPUT_CHANNEL[DRC_DW-1:0] == def_cal)
      else $error("output left ground without load");
   c_reset_done: cover property (@(posedge I_CLK) $fell(O_RESET_BUSY));
   c_clear_cycle: cover property (@(posedge I_CLK) $rose(I_OUTPUT_FORCE_GROUND_N));
   c_load_done: cover property (@(posedge I_CLK) load_ok && dirty_ff != '0);
endmodule

// >>> drc_host.sv
`timescale 1ns/10ps
// ***************************************************
// host controller model
// ***************************************************
module drc_host
   import drc_pkg::*;
#(
   parameter int GUARD = 24
) (
   // clock, reset, status
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_busy,
   // control pins
   output logic o_dev_reset_n,
   output logic o_clear_n,
   output logic o_load_n,
   // write port
   output logic o_wr,
   output logic [1:0] o_wr_sel,
   output logic [DRC_CHW-1:0] o_wr_ch,
   output logic [DRC_DW-1:0] o_wr_data
);
   int guard_cnt;
   initial begin
      o_dev_reset_n = 1'b1;
      o_clear_n = 1'b1;
      o_load_n = 1'b1;
      o_wr = 1'b0;
      o_wr_sel = 2'h0;
      o_wr_ch = 5'h00;
      o_wr_data = 14'h0000;
   end
   // margin over the sequence length, since the pin rise is seen one edge late
   always @(posedge i_clk) begin
      if (!i_rst_n || !o_dev_reset_n) guard_cnt <= 0;
      else if (guard_cnt < GUARD) guard_cnt <= guard_cnt + 1;
   end
   task automatic wr(input logic [1:0] sel, input logic [DRC_CHW-1:0] ch, input logic [DRC_DW-1:0] d);
      int n;
      n = 0;
      @(posedge i_clk);
      while ((guard_cnt < GUARD || i_busy !== 1'b0) && n < 1000) begin
         @(posedge i_clk);
         n++;
      end
      o_wr <= 1'b1;
      o_wr_sel <= sel;
      o_wr_ch <= ch;
      o_wr_data <= d;
      @(posedge i_clk);
      // released data never shows the stale word
      o_wr <= 1'b0;
      o_wr_data <= ~d;
      @(posedge i_clk);
   endtask
   task automatic set_reset(input logic v);
      @(posedge i_clk);
      o_dev_reset_n <= v;
   endtask
   task automatic set_clear(input logic v);
      @(posedge i_clk);
      o_clear_n <= v;
   endtask
   task automatic load();
      @(posedge i_clk);
      o_load_n <= 1'b0;
      @(posedge i_clk);
      o_load_n <= 1'b1;
      repeat (2) @(posedge i_clk);
   endtask
   // both errors are measured before either trim is written
   task automatic calibrate(input logic [DRC_CHW-1:0] ch, input logic [DRC_DW-1:0] zero_lsb,
                            input logic [DRC_DW-1:0] span_lsb);
      wr(2'h1, ch, DRC_GAIN_DEF - span_lsb);
      wr(2'h2, ch, DRC_OFS_DEF + zero_lsb);
   endtask
endmodule

// >>> drc_top_test.sv
`timescale 1ns/10ps
module drc_top_test;
   import drc_pkg::*;
   localparam int RST_CYC = 20;
   localparam logic [DRC_DW-1:0] GND = 14'h1555;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic dev_rst_n, clr_n, ld_n, wr;
   logic [1:0] wr_sel;
   logic [DRC_CHW-1:0] wr_ch;
   logic [DRC_DW-1:0] wr_data;
   logic [DRC_NCH*DRC_DW-1:0] outs;
   logic gnd_ref, busy;
   int failures = 0;
   int n_checks = 0;
   always #5 clk = ~clk;
   drc_top #(.NCH(DRC_NCH), .RST_CYC(RST_CYC)) drc_top_i (.I_CLK(clk), .I_RST_N(rst_n),
      .I_DEV_RESET_N(dev_rst_n), .I_OUTPUT_FORCE_GROUND_N(clr_n), .I_LOAD_OUTPUTS_N(ld_n),
      .I_WR(wr), .I_WR_SEL(wr_sel), .I_WR_CH(wr_ch), .I_WR_DATA(wr_data),
      .O_ANALOG_OUTPUT_CHANNEL(outs), .O_GROUP_SIGNAL_GROUND_REF(gnd_ref), .O_RESET_BUSY(busy));
   drc_host #(.GUARD(RST_CYC + 4)) drc_host_i (.i_clk(clk), .i_rst_n(rst_n), .i_busy(busy),
      .o_dev_reset_n(dev_rst_n), .o_clear_n(clr_n), .o_load_n(ld_n), .o_wr(wr),
      .o_wr_sel(wr_sel), .o_wr_ch(wr_ch), .o_wr_data(wr_data));
   // ***************************************************
   // compare and report
   // ***************************************************
   task automatic chk_code(input logic [DRC_DW-1:0] got, input logic [DRC_DW-1:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t code %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_flag(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %0t flag %b expected %b", $time, got, exp);
      end
   endtask
   function automatic logic [DRC_DW-1:0] out_ch(input int i);
      return outs[DRC_DW*i +: DRC_DW];
   endfunction
   task automatic print_verdict();
      if (failures == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // ***************************************************
   // scenarios
   // ***************************************************
   task automatic t_reset();
      int n;
      drc_host_i.wr(2'h0, 5'h03, 14'h0123);
      drc_host_i.load();
      chk_code(out_ch(3), 14'h0123);
      drc_host_i.set_reset(1'b0);
      repeat (5) @(posedge clk);
      chk_code(out_ch(3), 14'h0123);
      chk_flag(busy, 1'b0);
      drc_host_i.set_reset(1'b1); // low for 6 cycles
      n = 0;
      while (busy !== 1'b1 && n < 10) begin
         @(posedge clk);
         n++;
      end
      n = 0;
      while (busy === 1'b1 && n < 1000) begin
         @(posedge clk);
         n++;
      end
      chk_flag(n >= RST_CYC && n <= RST_CYC + 1, 1'b1);
      for (int i = 0; i < DRC_NCH; i++) chk_code(out_ch(i), GND);
   endtask
   task automatic t_write();
      drc_host_i.wr(2'h0, 5'h05, 14'h0100);
      repeat (3) @(posedge clk);
      chk_code(out_ch(5), GND);
      drc_host_i.load();
      chk_code(out_ch(5), 14'h0100);
      chk_code(out_ch(6), GND);
   endtask
   task automatic t_cal();
      drc_host_i.calibrate(5'h07, 14'h0010, 14'h2000);
      drc_host_i.wr(2'h0, 5'h07, 14'h0800);
      drc_host_i.load();
      chk_code(out_ch(7), 14'h0410);
   endtask
   task automatic t_clear();
      drc_host_i.set_clear(1'b0);
      repeat (2) @(posedge clk);
      chk_code(out_ch(5), GND);
      chk_flag(gnd_ref, 1'b1);
      drc_host_i.wr(2'h0, 5'h05, 14'h0200);
      drc_host_i.load();
      chk_code(out_ch(5), GND);
      drc_host_i.set_clear(1'b1);
      repeat (2) @(posedge clk);
      chk_code(out_ch(5), 14'h0100);
      chk_flag(gnd_ref, 1'b0);
      drc_host_i.load();
      chk_code(out_ch(5), 14'h0200);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_write();
      t_cal();
      t_clear();
      print_verdict();
   end
   // whole run is well under 1000 cycles
   initial begin
      #200000;
      failures++;
      print_verdict();
   end
endmodule
